// ===== core/jtrc_tap_chains.sv
// test access port with instruction, boundary, identification, bypass and debug-port chains
// assumes tck_in from the tester, rst_n_in as power-on reset, one answer per debug request
`timescale 1ns/1ps

module jtrc_tap_chains #(
   parameter int NUM_PINS = 8,
   parameter logic [31:0] ID_VALUE = 32'h1000_0001 // arbitrary value, lsb must stay one
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   input wire logic [NUM_PINS-1:0] core_out_in,
   input wire logic [NUM_PINS-1:0] core_oe_in,
   input wire logic [NUM_PINS-1:0] pad_in_in,
   output logic [NUM_PINS-1:0] pad_out_out,
   output logic [NUM_PINS-1:0] pad_oe_out,
   output logic [NUM_PINS-1:0] core_in_out,
   output logic dap_req_valid_out,
   output logic [1:0] dap_req_kind_out,
   output logic [jtrc_pkg::DAP_W-1:0] dap_req_data_out,
   input wire logic dap_resp_valid_in,
   input wire logic [jtrc_pkg::DAP_W-1:0] dap_resp_data_in
);

   localparam int BSR_W = jtrc_pkg::CELLS_PER_PIN * NUM_PINS;
   localparam int DW = jtrc_pkg::DAP_W;

   // ************************************************************
   // tck-domain reset: asserts at once, releases after two tck edges
   // ************************************************************
   // only power-on reset reaches the tap; the system reset pin is not wired
   logic trst_s1;
   logic tck_rst_n;
   always_ff @(posedge tck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         trst_s1 <= 1'b0;
         tck_rst_n <= 1'b0;
      end else begin
         trst_s1 <= 1'b1;
         tck_rst_n <= trst_s1;
      end
   end

   // ************************************************************
   // tap controller
   // ************************************************************
   jtrc_pkg::jtrc_state_t state;
   jtrc_pkg::jtrc_state_t next_state;

   always_comb begin
      case (state)
         jtrc_pkg::ST_RESET: next_state = tms_in ? jtrc_pkg::ST_RESET : jtrc_pkg::ST_IDLE;
         jtrc_pkg::ST_IDLE: next_state = tms_in ? jtrc_pkg::ST_SEL_DR : jtrc_pkg::ST_IDLE;
         jtrc_pkg::ST_SEL_DR: next_state = tms_in ? jtrc_pkg::ST_SEL_IR : jtrc_pkg::ST_CAP_DR;
         jtrc_pkg::ST_CAP_DR: next_state = tms_in ? jtrc_pkg::ST_EXIT1_DR : jtrc_pkg::ST_SHIFT_DR;
         jtrc_pkg::ST_SHIFT_DR: next_state = tms_in ? jtrc_pkg::ST_EXIT1_DR : jtrc_pkg::ST_SHIFT_DR;
         jtrc_pkg::ST_EXIT1_DR: next_state = tms_in ? jtrc_pkg::ST_UPD_DR : jtrc_pkg::ST_PAUSE_DR;
         jtrc_pkg::ST_PAUSE_DR: next_state = tms_in ? jtrc_pkg::ST_EXIT2_DR : jtrc_pkg::ST_PAUSE_DR;
         jtrc_pkg::ST_EXIT2_DR: next_state = tms_in ? jtrc_pkg::ST_UPD_DR : jtrc_pkg::ST_SHIFT_DR;
         jtrc_pkg::ST_UPD_DR: next_state = tms_in ? jtrc_pkg::ST_SEL_DR : jtrc_pkg::ST_IDLE;
         jtrc_pkg::ST_SEL_IR: next_state = tms_in ? jtrc_pkg::ST_RESET : jtrc_pkg::ST_CAP_IR;
         jtrc_pkg::ST_CAP_IR: next_state = tms_in ? jtrc_pkg::ST_EXIT1_IR : jtrc_pkg::ST_SHIFT_IR;
         jtrc_pkg::ST_SHIFT_IR: next_state = tms_in ? jtrc_pkg::ST_EXIT1_IR : jtrc_pkg::ST_SHIFT_IR;
         jtrc_pkg::ST_EXIT1_IR: next_state = tms_in ? jtrc_pkg::ST_UPD_IR : jtrc_pkg::ST_PAUSE_IR;
         jtrc_pkg::ST_PAUSE_IR: next_state = tms_in ? jtrc_pkg::ST_EXIT2_IR : jtrc_pkg::ST_PAUSE_IR;
         jtrc_pkg::ST_EXIT2_IR: next_state = tms_in ? jtrc_pkg::ST_UPD_IR : jtrc_pkg::ST_SHIFT_IR;
         jtrc_pkg::ST_UPD_IR: next_state = tms_in ? jtrc_pkg::ST_SEL_DR : jtrc_pkg::ST_IDLE;
         default: next_state = jtrc_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         state <= jtrc_pkg::ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   wire st_cap_dr = (state == jtrc_pkg::ST_CAP_DR);
   wire st_shift_dr = (state == jtrc_pkg::ST_SHIFT_DR);
   wire st_upd_dr = (state == jtrc_pkg::ST_UPD_DR);
   wire st_shift_ir = (state == jtrc_pkg::ST_SHIFT_IR);

   // ************************************************************
   // instruction chain and decode
   // ************************************************************
   logic [jtrc_pkg::IR_W-1:0] ir_shift;
   logic [jtrc_pkg::IR_W-1:0] ir_hold;

   always_ff @(posedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_shift <= jtrc_pkg::IR_CAPTURE;
         ir_hold <= jtrc_pkg::IR_IDENT;
      end else begin
         if (state == jtrc_pkg::ST_CAP_IR) begin
            ir_shift <= jtrc_pkg::IR_CAPTURE;
         end else if (st_shift_ir) begin
            ir_shift <= {tdi_in, ir_shift[jtrc_pkg::IR_W-1:1]};
         end
         if (state == jtrc_pkg::ST_RESET) begin
            ir_hold <= jtrc_pkg::IR_IDENT;
         end else if (state == jtrc_pkg::ST_UPD_IR) begin
            ir_hold <= ir_shift;
         end
      end
   end

   wire sel_extest = (ir_hold == jtrc_pkg::IR_EXTEST);
   wire sel_intest = (ir_hold == jtrc_pkg::IR_INTEST);
   wire sel_sample = (ir_hold == jtrc_pkg::IR_SAMPLE);
   wire sel_abort = (ir_hold == jtrc_pkg::IR_ABORT);
   wire sel_dp = (ir_hold == jtrc_pkg::IR_DP_REQ);
   wire sel_ap = (ir_hold == jtrc_pkg::IR_AP_REQ);
   wire sel_id = (ir_hold == jtrc_pkg::IR_IDENT);
   wire sel_bsr = sel_extest | sel_intest | sel_sample;
   wire sel_dap = sel_abort | sel_dp | sel_ap;
   // every other code, 1111 included, lands on the bypass stage
   wire sel_bypass = !(sel_bsr | sel_dap | sel_id);

   // ************************************************************
   // pad sampling: two flops before the boundary chain reads them
   // ************************************************************
   logic [BSR_W-1:0] pad_s1;
   logic [BSR_W-1:0] pad_s2;
   logic [BSR_W-1:0] pad_raw;

   always_ff @(posedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         pad_s1 <= '0;
         pad_s2 <= '0;
      end else begin
         pad_s1 <= pad_raw;
         pad_s2 <= pad_s1;
      end
   end

   // ************************************************************
   // boundary chain and pad muxing, one generate per pin
   // ************************************************************
   logic [BSR_W-1:0] bsr_shift;
   logic [BSR_W-1:0] bsr_hold;

   // pin 0 sits next to the test port and shifts out first
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      localparam int B = jtrc_pkg::CELLS_PER_PIN * p;
      assign pad_raw[B + jtrc_pkg::CELL_IN] = pad_in_in[p];
      assign pad_raw[B + jtrc_pkg::CELL_OUT] = pad_out_out[p];
      assign pad_raw[B + jtrc_pkg::CELL_OE] = pad_oe_out[p];
      assign pad_out_out[p] = sel_extest ? bsr_hold[B + jtrc_pkg::CELL_OUT] : core_out_in[p];
      assign pad_oe_out[p] = sel_extest ? bsr_hold[B + jtrc_pkg::CELL_OE] : core_oe_in[p];
      assign core_in_out[p] = sel_intest ? bsr_hold[B + jtrc_pkg::CELL_IN] : pad_in_in[p];
   end

   always_ff @(posedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bsr_shift <= '0;
         bsr_hold <= '0;
      end else begin
         if (sel_bsr && st_cap_dr) begin
            bsr_shift <= pad_s2;
         end else if (sel_bsr && st_shift_dr) begin
            bsr_shift <= {tdi_in, bsr_shift[BSR_W-1:1]};
         end
         if (sel_bsr && st_upd_dr) begin
            bsr_hold <= bsr_shift;
         end
      end
   end

   // ************************************************************
   // identification, bypass and debug access port chains
   // ************************************************************
   logic [jtrc_pkg::ID_W-1:0] id_shift;
   logic bypass_shift;
   logic [DW-1:0] dap_shift;
   logic [DW-1:0] req_data;
   logic [1:0] req_kind;
   logic req_tgl;
   logic ack_s1;
   logic ack_s2;
   logic ack_tgl;
   logic [DW-1:0] resp_data;

   // a capture before the answer is back reports wait, except after an abort sent over a pending request, which reads the old word
   wire req_done = (ack_s2 == req_tgl);
   wire [DW-1:0] dap_capture = req_done ? resp_data
                                        : {{(DW - jtrc_pkg::ACK_W){1'b0}}, jtrc_pkg::ACK_WAIT};
   wire [1:0] kind_sel = sel_abort ? jtrc_pkg::KIND_ABORT
                                   : (sel_dp ? jtrc_pkg::KIND_DP : jtrc_pkg::KIND_AP);

   always_ff @(posedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         id_shift <= '0;
         bypass_shift <= 1'b0;
      end else begin
         if (sel_id && st_cap_dr) begin
            id_shift <= ID_VALUE;
         end else if (sel_id && st_shift_dr) begin
            id_shift <= {tdi_in, id_shift[jtrc_pkg::ID_W-1:1]};
         end
         if (sel_bypass && st_cap_dr) begin
            bypass_shift <= 1'b0;
         end else if (sel_bypass && st_shift_dr) begin
            bypass_shift <= tdi_in;
         end
      end
   end

   // one 35-bit shifter serves all three chains since only one is selected
   always_ff @(posedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         dap_shift <= '0;
         req_data <= '0;
         req_kind <= jtrc_pkg::KIND_ABORT;
         req_tgl <= 1'b0;
      end else begin
         if (sel_dap && st_cap_dr) begin
            dap_shift <= dap_capture;
         end else if (sel_dap && st_shift_dr) begin
            dap_shift <= {tdi_in, dap_shift[DW-1:1]};
         end
         // abort goes out even while a request is pending, so it can cancel it
         if (sel_dap && st_upd_dr && (req_done || sel_abort)) begin
            req_data <= dap_shift;
            req_kind <= kind_sel;
            req_tgl <= ~req_tgl;
         end
      end
   end

   always_ff @(posedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
      end
   end

   // ************************************************************
   // system-clock side: toggle handshake to the debug access port
   // ************************************************************
   logic req_s1;
   logic req_s2;
   logic req_s3;
   wire req_edge = req_s2 ^ req_s3;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         dap_req_valid_out <= 1'b0;
         dap_req_kind_out <= jtrc_pkg::KIND_ABORT;
         dap_req_data_out <= '0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         dap_req_valid_out <= req_edge;
         if (req_edge) begin
            dap_req_kind_out <= req_kind; // held since the toggle, safe to take
            dap_req_data_out <= req_data;
         end
      end
   end

   // the answer word is loaded on the same edge the ack toggle leaves and then held, so tck may read it
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         resp_data <= '0;
         ack_tgl <= 1'b0;
      end else if (dap_resp_valid_in) begin
         resp_data <= dap_resp_data_in;
         ack_tgl <= ~ack_tgl;
      end
   end

   // ************************************************************
   // tdo on the falling edge, driven only in the shift states
   // ************************************************************
   wire dr_bit = sel_bsr ? bsr_shift[0] :
                 sel_dap ? dap_shift[0] :
                 sel_id ? id_shift[0] : bypass_shift;
   wire next_tdo = st_shift_ir ? ir_shift[0] : dr_bit;

   always_ff @(negedge tck_in or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else begin
         tdo_out <= next_tdo;
         tdo_oe_out <= st_shift_ir | st_shift_dr;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_ir_shift_keeps_hold;
      @(posedge tck_in) disable iff (!tck_rst_n)
      st_shift_ir |=> $stable(ir_hold);
   endproperty
   a_ir_shift_keeps_hold: assert property (p_ir_shift_keeps_hold)
      else $error("instruction changed while shifting");
   property p_ir_update;
      @(posedge tck_in) disable iff (!tck_rst_n)
      (state == jtrc_pkg::ST_UPD_IR) |=> (ir_hold == $past(ir_shift));
   endproperty
   a_ir_update: assert property (p_ir_update)
      else $error("update did not load the instruction");
   property p_reset_ident;
      @(posedge tck_in) disable iff (!tck_rst_n)
      (state == jtrc_pkg::ST_RESET) |=> (ir_hold == jtrc_pkg::IR_IDENT);
   endproperty
   a_reset_ident: assert property (p_reset_ident)
      else $error("test-logic-reset did not select identification");
   property p_tms_five_resets;
      @(posedge tck_in) disable iff (!tck_rst_n)
      tms_in [*5] |=> (state == jtrc_pkg::ST_RESET);
   endproperty
   a_tms_five_resets: assert property (p_tms_five_resets)
      else $error("five tms highs did not reach reset");
   property p_capture_ir;
      @(posedge tck_in) disable iff (!tck_rst_n)
      (state == jtrc_pkg::ST_CAP_IR) |=> (ir_shift[1:0] == 2'b01);
   endproperty
   a_capture_ir: assert property (p_capture_ir)
      else $error("capture-ir pattern wrong");
   property p_ident_capture;
      @(posedge tck_in) disable iff (!tck_rst_n)
      (sel_id && st_cap_dr) |=> (id_shift == ID_VALUE) && id_shift[0];
   endproperty
   a_ident_capture: assert property (p_ident_capture)
      else $error("identification capture wrong");
   property p_bypass_zero;
      @(posedge tck_in) disable iff (!tck_rst_n)
      (st_cap_dr && (ir_hold == jtrc_pkg::IR_BYPASS || ir_hold == 4'h5)) |=> !bypass_shift;
   endproperty
   a_bypass_zero: assert property (p_bypass_zero)
      else $error("bypass did not capture zero");
   property p_bsr_shift;
      @(posedge tck_in) disable iff (!tck_rst_n)
      (sel_bsr && st_shift_dr) |=>
         (bsr_shift == {$past(tdi_in), $past(bsr_shift[BSR_W-1:1])});
   endproperty
   a_bsr_shift: assert property (p_bsr_shift)
      else $error("boundary chain did not shift");
   property p_bsr_update;
      @(posedge tck_in) disable iff (!tck_rst_n)
      (sel_bsr && st_upd_dr) |=> (bsr_hold == $past(bsr_shift));
   endproperty
   a_bsr_update: assert property (p_bsr_update)
      else $error("boundary holding cells not updated");
   property p_req_single;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      dap_req_valid_out |=> !dap_req_valid_out;
   endproperty
   a_req_single: assert property (p_req_single)
      else $error("request pulse longer than one cycle");

endmodule

// ===== core/jtrc_pkg.sv
// constants for the test-port instruction and data chains
// assumes a single tester on the serial pins and a debug access port on the system clock
package jtrc_pkg;

   // ************************************************************
   // instruction codes and chain widths
   // ************************************************************
   localparam int IR_W = 4;
   localparam logic [3:0] IR_EXTEST = 4'h0;
   localparam logic [3:0] IR_INTEST = 4'h1;
   localparam logic [3:0] IR_SAMPLE = 4'h2;
   localparam logic [3:0] IR_ABORT = 4'h8;
   localparam logic [3:0] IR_DP_REQ = 4'hA;
   localparam logic [3:0] IR_AP_REQ = 4'hB;
   localparam logic [3:0] IR_IDENT = 4'hE;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam int ID_W = 32;
   localparam int DAP_W = 35;
   localparam int CELLS_PER_PIN = 3;
   localparam int CELL_IN = 0;
   localparam int CELL_OUT = 1;
   localparam int CELL_OE = 2;

   // ************************************************************
   // debug access port request kinds and acknowledge codes
   // ************************************************************
   localparam logic [1:0] KIND_ABORT = 2'h0;
   localparam logic [1:0] KIND_DP = 2'h1;
   localparam logic [1:0] KIND_AP = 2'h2;
   localparam logic [2:0] ACK_WAIT = 3'h1;
   localparam int ACK_W = 3;

   // ************************************************************
   // tap controller states
   // ************************************************************
   typedef enum logic [3:0] {
      ST_RESET = 4'h0,
      ST_IDLE = 4'h1,
      ST_SEL_DR = 4'h2,
      ST_CAP_DR = 4'h3,
      ST_SHIFT_DR = 4'h4,
      ST_EXIT1_DR = 4'h5,
      ST_PAUSE_DR = 4'h6,
      ST_EXIT2_DR = 4'h7,
      ST_UPD_DR = 4'h8,
      ST_SEL_IR = 4'h9,
      ST_CAP_IR = 4'hA,
      ST_SHIFT_IR = 4'hB,
      ST_EXIT1_IR = 4'hC,
      ST_PAUSE_IR = 4'hD,
      ST_EXIT2_IR = 4'hE,
      ST_UPD_IR = 4'hF
   } jtrc_state_t;

endpackage

// ===== tb/jtrc_tester.sv
// serial test probe model: drives tck, tms and tdi, samples tdo
// assumes the bench calls its tasks; tck stands low between scans
`timescale 1ns/1ps

module jtrc_tester (
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   input wire logic tdo_in
);
   // ************************************************************
   // link cycles
   // ************************************************************
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end

   // one 6 ns tck period; tdo is taken at rising tck, launched on falling
   task automatic pulse(input logic tms, input logic tdi, output logic tdo);
      tms_out <= tms;
      tdi_out <= tdi;
      #3;
      tdo = tdo_in;
      tck_out <= 1'b1;
      #3;
      tck_out <= 1'b0;
   endtask

   // five highs reach test-logic-reset from anywhere, then park in idle
   task automatic tlr();
      logic t;
      repeat (5) pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
   endtask

   // idle to idle through one ir or dr scan, lsb first
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
      logic t;
      dout = '0;
      pulse(1'b1, 1'b0, t);
      if (ir) pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      pulse(1'b0, 1'b0, t);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], t);
         dout[i] = t;
      end
      pulse(1'b1, 1'b0, t);
      pulse(1'b0, 1'b0, t);
   endtask
endmodule

// ===== tb/jtrc_tap_chains_tb_top.sv
// self-checking bench for the test-port chains
// assumes the probe model drives the link; a stand-in answers debug requests
`timescale 1ns/1ps

module jtrc_tap_chains_tb_top;
   localparam int N = 8;
   localparam int BW = 3 * N;
   localparam logic [31:0] ID = 32'h2468_ace1; // arbitrary value, lsb one
   localparam logic [34:0] RESP = 35'h5_1234_5672;
   localparam logic [23:0] P = 24'h96_3c5a;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, req_v;
   logic resp_v = 1'b0;
   logic [N-1:0] core_out, core_oe, pad_in, pad_out, pad_oe, core_in;
   logic [1:0] req_kind, got_kind;
   logic [34:0] req_data, got_data;
   logic [63:0] d;
   logic oe_seen = 1'b0;
   int got_n = 0;
   int fails = 0;
   int tests_run = 0;

   initial forever #4 ref_clk = ~ref_clk;

   jtrc_tap_chains #(.NUM_PINS(N), .ID_VALUE(ID)) uut (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
      .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
      .core_out_in(core_out), .core_oe_in(core_oe), .pad_in_in(pad_in),
      .pad_out_out(pad_out), .pad_oe_out(pad_oe), .core_in_out(core_in),
      .dap_req_valid_out(req_v), .dap_req_kind_out(req_kind), .dap_req_data_out(req_data),
      .dap_resp_valid_in(resp_v), .dap_resp_data_in(RESP));
   jtrc_tester probe (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));

   // debug port stand-in: exactly one answer, a cycle after each request
   always @(posedge ref_clk) begin
      resp_v <= req_v;
      if (req_v) begin
         got_n <= got_n + 1;
         got_kind <= req_kind;
         got_data <= req_data;
      end
   end

   // tdo enable must rise during shifts and fall back outside them
   always @(posedge tck) if (tdo_oe) oe_seen <= 1'b1;

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (fails == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   function automatic logic [BW-1:0] bexp(input logic [N-1:0] i, o, e);
      logic [BW-1:0] r;
      for (int p = 0; p < N; p++) r[3*p +: 3] = {e[p], o[p], i[p]};
      return r;
   endfunction

   function automatic logic [N-1:0] cells(input logic [BW-1:0] c, input int k);
      for (int p = 0; p < N; p++) cells[p] = c[3*p+k];
   endfunction

   // bounded wait, then let the answer cross back on idle tck edges
   task automatic wait_req(input int n);
      logic t;
      for (int k = 0; k < 40 && got_n < n; k++) @(posedge ref_clk);
      check(got_n, n);
      if (got_n != n) close_out();
      repeat (3) @(posedge ref_clk);
      repeat (3) probe.pulse(1'b0, 1'b0, t);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_ident();
      probe.scan(1'b0, 32, 64'h0, d);
      check(d, ID);
      check({oe_seen, tdo_oe}, 2'b10);
      probe.scan(1'b1, 4, jtrc_pkg::IR_BYPASS, d);
      check(d, 64'h1);
      probe.scan(1'b0, 2, 64'h3, d);
      check(d, 64'h2);
      probe.tlr();
      probe.scan(1'b0, 32, 64'h0, d);
      check(d, ID);
   endtask

   task automatic t_unlisted();
      logic [3:0] codes [8] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd};
      for (int i = 0; i < 8; i++) begin
         probe.scan(1'b1, 4, codes[i], d);
         probe.scan(1'b0, 2, 64'h3, d);
         check(d, 64'h2);
      end
   endtask

   task automatic t_boundary();
      probe.scan(1'b1, 4, jtrc_pkg::IR_SAMPLE, d);
      probe.scan(1'b0, BW, P, d);
      check(d, bexp(pad_in, core_out, core_oe));
      check({pad_out, pad_oe, core_in}, {core_out, core_oe, pad_in});
      probe.scan(1'b1, 4, jtrc_pkg::IR_EXTEST, d);
      check({pad_out, pad_oe, core_in}, {cells(P, 1), cells(P, 2), pad_in});
      probe.scan(1'b0, BW, ~P, d);
      check(d, bexp(pad_in, cells(P, 1), cells(P, 2)));
      check({pad_out, pad_oe}, {cells(~P, 1), cells(~P, 2)});
      probe.scan(1'b1, 4, jtrc_pkg::IR_INTEST, d);
      check({pad_out, pad_oe, core_in}, {core_out, core_oe, cells(~P, 0)});
   endtask

   task automatic t_dap();
      logic [3:0] codes [3] = '{jtrc_pkg::IR_ABORT, jtrc_pkg::IR_DP_REQ, jtrc_pkg::IR_AP_REQ};
      logic [1:0] kinds [3] = '{jtrc_pkg::KIND_ABORT, jtrc_pkg::KIND_DP, jtrc_pkg::KIND_AP};
      logic [34:0] w;
      int n;
      n = 0;
      for (int i = 0; i < 3; i++) begin
         w = 35'h2_a5a5_0f0f ^ 35'(i);
         probe.scan(1'b1, 4, codes[i], d);
         probe.scan(1'b0, 35, w, d);
         n++;
         wait_req(n);
         check({got_kind, got_data}, {kinds[i], w});
         probe.scan(1'b0, 35, 64'h0, d);
         n++;
         wait_req(n);
         if (i > 0) check(d, RESP);
      end
      // a capture right after an update comes before the answer, so it reads wait
      probe.scan(1'b0, 35, w, d);
      probe.scan(1'b0, 35, 64'h0, d);
      check(d, 64'(jtrc_pkg::ACK_WAIT));
      n += 2;
      wait_req(n);
   endtask

   // power-on reset mid-run drops extest and brings back identification
   task automatic t_por();
      probe.scan(1'b1, 4, jtrc_pkg::IR_EXTEST, d);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check({pad_out, pad_oe}, {core_out, core_oe});
      rst_n <= 1'b1;
      @(posedge ref_clk);
      probe.tlr();
      probe.scan(1'b0, 32, 64'h0, d);
      check(d, ID);
   endtask

   initial begin
      core_out <= 8'h3c;
      core_oe <= 8'hf0;
      pad_in <= 8'ha5;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      probe.tlr();
      t_ident();
      t_unlisted();
      t_boundary();
      t_dap();
      t_por();
      close_out();
   end
endmodule
